// ---- pkg/flash_lock_regs.vh ----
// Overview of operation
// - largest build has two controllers, 16 lock bits each, 32 regions of 64x256-byte pages.
// - single-controller large build has 16 regions of 64 pages of 256 bytes.
// - mid build has 8 regions and 8 lock bits, 64 pages of 256 bytes each.
// - small build has 16 regions of 32 pages of 128 bytes.
// - smallest build has 8 regions of 32 pages of 128 bytes.
// - erase or program aimed at a locked region aborts and sets the lock-error flag.
// - interrupt rises on lock error only when the mode-register enable bit is 1.
// - set-lock and clear-lock commands update the selected region's lock bit.
// - asserting the nonvolatile-clear pin clears every lock bit.
// - eight factory calibration bits ignore user writes and the clear pin.
// - test pin high, select 0 and 1 high, select 2 low enters fast programming.
// - fast port offers read, page program, page erase, full erase, lock, unlock, protect.
// - all four strap pins high for 10 seconds restores boot loader; then power cycle.
// - brownout detector enable follows general-purpose nonvolatile bit 0.
// - power-on or brownout unsafe supply inhibits all flash-modifying operations; the boot restore pulse is not gated by the supply.
`ifndef FLASH_LOCK_REGS_VH
`define FLASH_LOCK_REGS_VH

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define CMD_READ        4'h0
`define CMD_PAGE_PROG   4'h1
`define CMD_PAGE_ERASE  4'h2
`define CMD_FULL_ERASE  4'h3
`define CMD_SET_LOCK    4'h4
`define CMD_CLR_LOCK    4'h5
`define CMD_PROTECT     4'h6
`define CMD_SET_GPNV    4'h7
`define CMD_CLR_GPNV    4'h8

// ----------------------------------------------------------------------
// status field positions and mode bit
// ----------------------------------------------------------------------
`define FSR_READY_BIT   0
`define FSR_LOCKERR_BIT 2
`define FSR_PROGE_BIT   3
`define FSR_PROT_BIT    4
`define FMR_LOCKERR_EN  2

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define CALIB_RESET     8'h5a
`define GPNV_RESET      2'h1
`define OP_CYCLES       8'h08
`define CLK_HZ          20000000
`define RECOVER_SEC     10
`define RECOVER_CYCLES  (`CLK_HZ * `RECOVER_SEC)

`endif

// ---- design/strap_sync.v ----
`timescale 1ns/1ps
// three-stage pin synchroniser, change accepted when stages two and three agree
module strap_sync #(
  parameter WIDTH = 4
) (
  input  wire             clk_i,
  input  wire             srst_i,
  input  wire [WIDTH-1:0] pin_i,
  output wire [WIDTH-1:0] level_o
);
  genvar g;

  // ----------------------------------------------------------------------
  // per-bit chain
  // ----------------------------------------------------------------------
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : bit_chain
      reg s1_reg;
      reg s2_reg;
      reg s3_reg;
      reg level_reg;
      // first stage feeds only the second to keep metastability contained
      always @(posedge clk_i) begin
        if (srst_i) begin
          s1_reg    <= 1'b0;
          s2_reg    <= 1'b0;
          s3_reg    <= 1'b0;
          level_reg <= 1'b0;
        end else begin
          s1_reg <= pin_i[g];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            level_reg <= s3_reg;
          end
        end
      end
      // each bit owns its registers, so every signal has one driver
      assign level_o[g] = level_reg;
    end
  endgenerate
endmodule

// ---- design/flash_lock_region_protect.v ----
`timescale 1ns/1ps
`include "flash_lock_regs.vh"
module flash_lock_region_protect #(
  parameter NUM_CTRL       = 2,        // 1 or 2 controllers
  parameter LOCK_BITS      = 16,       // lock bits per controller
  parameter PAGE_SHIFT     = 6,        // log2 pages per region: 6 -> 64, 5 -> 32
  parameter PAGE_BYTES     = 256,      // bytes per page (information only)
  parameter PAGE_W         = 11,       // width of target page number
  parameter RECOVER_CYCLES = `RECOVER_CYCLES
) (
  // clock and reset
  input  wire                           clk_i,
  input  wire                           srst_i,
  // command request
  input  wire                           cmd_valid_i,
  input  wire [3:0]                     cmd_code_i,
  input  wire [PAGE_W-1:0]              cmd_page_i,
  input  wire                           gpnv_sel_i,
  // mode register bits
  input  wire                           mode_wr_i,
  input  wire [7:0]                     mode_data_i,
  input  wire                           status_rd_i,
  // calibration write attempt (always refused)
  input  wire                           calib_wr_i,
  input  wire [7:0]                     calib_data_i,
  // supply monitors
  input  wire                           por_ok_i,
  input  wire                           bod_ok_i,
  // pins
  input  wire                           nv_clear_pin_i,
  input  wire                           test_mode_pin_i,
  input  wire                           mode_select_pin_0_i,
  input  wire                           mode_select_pin_1_i,
  input  wire                           mode_select_pin_2_i,
  // results
  output reg  [7:0]                     flash_status_reg_o,
  output reg  [7:0]                     flash_mode_reg_o,
  output reg  [NUM_CTRL*LOCK_BITS-1:0]  lock_bits_o,
  output reg                            irq_o,
  output reg                            busy_o,
  output reg                            op_start_o,
  output reg  [3:0]                     op_code_o,
  output reg  [PAGE_W-1:0]              op_page_o,
  output reg  [7:0]                     calib_o,
  output reg                            bod_enable_o,
  output reg                            fast_prog_port_en_o,
  output reg                            boot_restore_o,
  output reg                            power_cycle_req_o
);
  localparam NREG = NUM_CTRL * LOCK_BITS;
  localparam [7:0] OP_CYC = `OP_CYCLES;
  // one-hot states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_BUSY = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  wire [4:0] pins_sync;
  reg  [2:0] state_reg;
  reg  [7:0] cnt_reg;
  reg  [NREG-1:0] lock_reg;
  reg  [1:0] gpnv_reg;
  reg  [31:0] hold_reg;
  reg        lock_error_flag;
  reg        prog_err_reg;
  reg        prot_reg;
  reg        fast_mode_reg;
  reg        recover_done_reg;

  // ----------------------------------------------------------------------
  // strap synchronisers
  // ----------------------------------------------------------------------
  // clear pin is an outside pin as well, so it rides the same chain
  strap_sync #(
    .WIDTH (5)
  ) u_sync (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .pin_i   ({nv_clear_pin_i, mode_select_pin_2_i, mode_select_pin_1_i, mode_select_pin_0_i, test_mode_pin_i}),
    .level_o (pins_sync)
  );

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  // region from page: upper bits; both controllers see one flat index
  function [PAGE_W-1:0] region_of;
    input [PAGE_W-1:0] page;
    begin
      region_of = page >> PAGE_SHIFT;
    end
  endfunction

  // commands that change flash contents
  function is_modify;
    input [3:0] code;
    begin
      is_modify = (code == `CMD_PAGE_PROG) || (code == `CMD_PAGE_ERASE) ||
                  (code == `CMD_FULL_ERASE);
    end
  endfunction

  wire [PAGE_W-1:0] cmd_region = region_of(cmd_page_i);
  wire region_ok  = (cmd_region < NREG);
  wire region_lck = region_ok ? lock_reg[cmd_region[4:0] % NREG] : 1'b0;
  wire any_lock   = |lock_reg;
  wire supply_ok  = por_ok_i & bod_ok_i;
  wire fast_entry = pins_sync[0] & pins_sync[1] & pins_sync[2] & ~pins_sync[3];
  wire recover_pins = &pins_sync[3:0];
  wire clear_pin  = pins_sync[4];                              // acts a few cycles after the pin
  wire known_cmd  = (cmd_code_i <= `CMD_CLR_GPNV);
  // full erase is blocked when any region is locked
  wire locked_hit = (cmd_code_i == `CMD_FULL_ERASE) ? any_lock :
                    (is_modify(cmd_code_i) & region_lck);
  wire take       = cmd_valid_i & (state_reg == ST_IDLE);

  // ----------------------------------------------------------------------
  // command sequencer and lock bits
  // ----------------------------------------------------------------------
  // clear pin is level sensitive: it wins over any set-lock in flight
  always @(posedge clk_i) begin
    if (srst_i) begin
      state_reg       <= ST_IDLE;
      cnt_reg         <= 8'h00;
      lock_reg        <= {NREG{1'b0}};
      gpnv_reg        <= `GPNV_RESET;
      lock_error_flag <= 1'b0;
      prog_err_reg    <= 1'b0;
      prot_reg        <= 1'b0;
      op_start_o      <= 1'b0;
      op_code_o       <= 4'h0;
      op_page_o       <= {PAGE_W{1'b0}};
    end else begin
      op_start_o <= 1'b0;
      // status read clears error flags, but a new event wins
      if (status_rd_i) begin
        lock_error_flag <= 1'b0;
        prog_err_reg    <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          if (take) begin
            if (!supply_ok || !known_cmd) begin
              prog_err_reg <= 1'b1;
            end else if (locked_hit) begin
              lock_error_flag <= 1'b1;
            end else begin
              op_start_o <= 1'b1;
              op_code_o  <= cmd_code_i;
              op_page_o  <= cmd_page_i;
              cnt_reg    <= OP_CYC;
              state_reg  <= ST_BUSY;
              case (cmd_code_i)
                `CMD_SET_LOCK: begin
                  if (region_ok) lock_reg[cmd_region[4:0] % NREG] <= 1'b1;
                end
                `CMD_CLR_LOCK: begin
                  if (region_ok) lock_reg[cmd_region[4:0] % NREG] <= 1'b0;
                end
                `CMD_PROTECT: prot_reg <= 1'b1;
                `CMD_SET_GPNV: gpnv_reg[gpnv_sel_i] <= 1'b1;
                `CMD_CLR_GPNV: gpnv_reg[gpnv_sel_i] <= 1'b0;
                default: ;
              endcase
            end
          end
        end
        ST_BUSY: begin
          if (!supply_ok) begin
            prog_err_reg <= 1'b1;
            state_reg    <= ST_DONE;
          end else if (cnt_reg == 8'h01) begin
            state_reg <= ST_DONE;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        ST_DONE: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
      if (clear_pin && supply_ok) begin
        lock_reg <= {NREG{1'b0}};
        prot_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // calibration bits: factory value only
  // ----------------------------------------------------------------------
  // user write and clear pin are deliberately ignored
  always @(posedge clk_i) begin
    if (srst_i) begin
      calib_o <= `CALIB_RESET;
    end else begin
      calib_o <= `CALIB_RESET;
    end
  end

  // ----------------------------------------------------------------------
  // strap modes
  // ----------------------------------------------------------------------
  // hold counter is a parameter so simulation can shorten ten seconds
  always @(posedge clk_i) begin
    if (srst_i) begin
      hold_reg         <= 32'h0000_0000;
      fast_mode_reg    <= 1'b0;
      recover_done_reg <= 1'b0;
      boot_restore_o   <= 1'b0;
    end else begin
      fast_mode_reg  <= fast_entry;
      boot_restore_o <= 1'b0;
      if (!recover_pins) begin
        hold_reg <= 32'h0000_0000;
      end else if (!recover_done_reg) begin
        if (hold_reg == RECOVER_CYCLES - 1) begin
          boot_restore_o   <= 1'b1;
          recover_done_reg <= 1'b1;
        end else begin
          hold_reg <= hold_reg + 32'h0000_0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (srst_i) begin
      flash_mode_reg_o    <= 8'h00;
      flash_status_reg_o  <= 8'h00;
      lock_bits_o         <= {NREG{1'b0}};
      irq_o               <= 1'b0;
      busy_o              <= 1'b0;
      bod_enable_o        <= 1'b0;
      fast_prog_port_en_o <= 1'b0;
      power_cycle_req_o   <= 1'b0;
    end else begin
      if (mode_wr_i) flash_mode_reg_o <= mode_data_i;
      flash_status_reg_o <= {3'h0, prot_reg, prog_err_reg, lock_error_flag, 1'b0,
                             (state_reg == ST_IDLE)};
      lock_bits_o  <= lock_reg;
      irq_o        <= lock_error_flag & flash_mode_reg_o[`FMR_LOCKERR_EN];
      busy_o       <= (state_reg != ST_IDLE);
      bod_enable_o <= gpnv_reg[0];
      fast_prog_port_en_o <= fast_mode_reg;
      power_cycle_req_o   <= recover_done_reg;
    end
  end
endmodule

// ---- bench/flash_lock_checker_sva.sv ----
`timescale 1ns/1ps
`include "flash_lock_regs.vh"
module flash_lock_checker #(
  parameter NUM_CTRL   = 2,
  parameter LOCK_BITS  = 16,
  parameter PAGE_SHIFT = 6,
  parameter PAGE_W     = 11
) (
  // clock, reset and requests
  input wire                          clk_i,
  input wire                          srst_i,
  input wire                          cmd_valid_i,
  input wire [3:0]                    cmd_code_i,
  input wire [PAGE_W-1:0]             cmd_page_i,
  input wire                          por_ok_i,
  input wire                          bod_ok_i,
  input wire                          nv_clear_pin_i,
  input wire                          test_mode_pin_i,
  input wire                          mode_select_pin_0_i,
  input wire                          mode_select_pin_1_i,
  input wire                          mode_select_pin_2_i,
  // results
  input wire [7:0]                    flash_status_reg_o,
  input wire [7:0]                    flash_mode_reg_o,
  input wire [NUM_CTRL*LOCK_BITS-1:0] lock_bits_o,
  input wire                          irq_o,
  input wire                          busy_o,
  input wire                          op_start_o,
  input wire [3:0]                    op_code_o,
  input wire [PAGE_W-1:0]             op_page_o,
  input wire [7:0]                    calib_o,
  input wire                          fast_prog_port_en_o,
  input wire                          boot_restore_o,
  input wire                          power_cycle_req_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  // only idle requests with a safe supply count, lagging lock view is settled then
  sequence s_locked_req;
    cmd_valid_i && !busy_o && flash_status_reg_o[`FSR_READY_BIT] && por_ok_i && bod_ok_i
    && (cmd_code_i == `CMD_PAGE_PROG || cmd_code_i == `CMD_PAGE_ERASE) && lock_bits_o[cmd_page_i >> PAGE_SHIFT];
  endsequence
  sequence s_fast_straps;
    (test_mode_pin_i && mode_select_pin_0_i && mode_select_pin_1_i && !mode_select_pin_2_i) [*8];
  endsequence
  sequence s_bad_supply;
    (!por_ok_i || !bod_ok_i) [*2];
  endsequence
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  a_locked_refused: assert property (s_locked_req |=> !op_start_o ##1 flash_status_reg_o[`FSR_LOCKERR_BIT])
    else $error("locked command was not refused with a lock error");
  a_locked_no_start: assert property (
    op_start_o && (op_code_o == `CMD_PAGE_PROG || op_code_o == `CMD_PAGE_ERASE) |-> !lock_bits_o[op_page_o >> PAGE_SHIFT])
    else $error("program or erase started in a locked region");
  a_irq_gated: assert property (!flash_mode_reg_o[`FMR_LOCKERR_EN] [*2] |-> !irq_o)
    else $error("interrupt raised while lock error enable is off");
  // clear pin passes a three-stage synchroniser, so it must stand eight cycles
  a_clear_pin_unlocks: assert property ((nv_clear_pin_i && por_ok_i && bod_ok_i) [*8] |=> lock_bits_o == '0)
    else $error("clear pin left a lock bit set");
  a_calib_fixed: assert property (calib_o == `CALIB_RESET)
    else $error("calibration bits changed");
  a_fast_mode_entry: assert property (s_fast_straps |-> fast_prog_port_en_o)
    else $error("fast programming not entered on strap pattern");
  a_restore_then_cycle: assert property (boot_restore_o |=> !boot_restore_o && power_cycle_req_o)
    else $error("boot restore not a single pulse followed by power cycle request");
  a_supply_no_start: assert property ((!por_ok_i || !bod_ok_i) |=> !op_start_o)
    else $error("operation started with unsafe supply");
  a_supply_locks_hold: assert property (s_bad_supply |=> $stable(lock_bits_o))
    else $error("lock bits changed with unsafe supply");
endmodule
bind flash_lock_region_protect flash_lock_checker #(
  .NUM_CTRL(NUM_CTRL), .LOCK_BITS(LOCK_BITS), .PAGE_SHIFT(PAGE_SHIFT), .PAGE_W(PAGE_W)
) flash_lock_checker_inst (
  .clk_i(clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .cmd_page_i(cmd_page_i),
  .por_ok_i(por_ok_i), .bod_ok_i(bod_ok_i), .nv_clear_pin_i(nv_clear_pin_i), .test_mode_pin_i(test_mode_pin_i),
  .mode_select_pin_0_i(mode_select_pin_0_i), .mode_select_pin_1_i(mode_select_pin_1_i),
  .mode_select_pin_2_i(mode_select_pin_2_i), .flash_status_reg_o(flash_status_reg_o),
  .flash_mode_reg_o(flash_mode_reg_o), .lock_bits_o(lock_bits_o), .irq_o(irq_o), .busy_o(busy_o),
  .op_start_o(op_start_o), .op_code_o(op_code_o), .op_page_o(op_page_o), .calib_o(calib_o),
  .fast_prog_port_en_o(fast_prog_port_en_o), .boot_restore_o(boot_restore_o), .power_cycle_req_o(power_cycle_req_o)
);

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`include "flash_lock_regs.vh"
module tb;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  reg         clk_i = 1'b0;
  reg         srst_i = 1'b1;
  reg         cmd_valid = 1'b0;
  reg  [3:0]  cmd_code = 4'h0;
  reg  [10:0] cmd_page = 11'h000;
  reg         gpnv_sel = 1'b0;
  reg         mode_wr = 1'b0;
  reg  [7:0]  mode_data = 8'h00;
  reg         status_rd = 1'b0;
  reg         calib_wr = 1'b0;
  reg         por_ok = 1'b1;
  reg         bod_ok = 1'b1;
  reg         nv_clear = 1'b0;
  reg  [3:0]  strap = 4'h0; // test, select 0, select 1, select 2
  wire [7:0]  status, mode, calib;
  wire [31:0] locks;
  wire [3:0]  op_code;
  wire [10:0] op_page;
  wire        irq, busy, start, bod_en, fast_en, restore, pcycle;
  integer     err_count = 0;
  integer     samples_checked = 0;
  reg         started;
  always #25 clk_i = ~clk_i;
  // short recovery count keeps the strap test within a few hundred cycles
  flash_lock_region_protect #(.RECOVER_CYCLES(50)) flash_lock_region_protect_inst (
    .clk_i(clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .cmd_page_i(cmd_page),
    .gpnv_sel_i(gpnv_sel), .mode_wr_i(mode_wr), .mode_data_i(mode_data), .status_rd_i(status_rd),
    .calib_wr_i(calib_wr), .calib_data_i(8'h00), .por_ok_i(por_ok), .bod_ok_i(bod_ok), .nv_clear_pin_i(nv_clear),
    .test_mode_pin_i(strap[3]), .mode_select_pin_0_i(strap[2]), .mode_select_pin_1_i(strap[1]),
    .mode_select_pin_2_i(strap[0]), .flash_status_reg_o(status), .flash_mode_reg_o(mode), .lock_bits_o(locks),
    .irq_o(irq), .busy_o(busy), .op_start_o(start), .op_code_o(op_code), .op_page_o(op_page), .calib_o(calib),
    .bod_enable_o(bod_en), .fast_prog_port_en_o(fast_en), .boot_restore_o(restore), .power_cycle_req_o(pcycle)
  );
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one request, then wait out the operation; records whether it started
  task issue(input [3:0] code, input [10:0] page);
    integer n;
    @(posedge clk_i);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    cmd_page <= page;
    @(posedge clk_i);
    cmd_valid <= 1'b0;
    started = 1'b0;
    for (n = 0; n < 40 && (n < 4 || busy !== 1'b0); n = n + 1) begin
      @(posedge clk_i);
      started = started | (start === 1'b1);
    end
  endtask
  task strobe(input integer which);
    @(posedge clk_i);
    if (which == 0) status_rd <= 1'b1; else mode_wr <= 1'b1;
    @(posedge clk_i);
    status_rd <= 1'b0;
    mode_wr <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_lock;
    integer k;
    mode_data <= 8'h04;
    strobe(1);
    chk("mode reg", mode, 32'h04);
    chk("calib", calib, 32'h5a);
    chk("bod enable", bod_en, 1);
    issue(`CMD_SET_LOCK, 11'd192);
    chk("lock 3", locks, 32'h0000_0008);
    issue(`CMD_SET_LOCK, 11'd2047);
    chk("lock 31", locks, 32'h8000_0008);
    // program, erase and full erase all hit a locked region
    for (k = 1; k <= 3; k = k + 1) begin
      issue(k[3:0], 11'd255);
      chk("locked start", started, 0);
      chk("lock error", status[`FSR_LOCKERR_BIT], 1);
      chk("irq", irq, 1);
      strobe(0);
      chk("error cleared", status[`FSR_LOCKERR_BIT], 0);
    end
    issue(`CMD_PAGE_ERASE, 11'd256);
    chk("free start", {started, op_code, op_page}, {1'b1, `CMD_PAGE_ERASE, 11'd256});
    issue(`CMD_READ, 11'd255);
    chk("read in locked region", started, 1);
    issue(`CMD_PROTECT, 11'd0);
    chk("protect set", status[`FSR_PROT_BIT], 1);
    issue(`CMD_CLR_LOCK, 11'd192);
    chk("unlock 3", locks, 32'h8000_0000);
    issue(`CMD_PAGE_PROG, 11'd200);
    chk("prog unlocked", started, 1);
    mode_data <= 8'h00;
    strobe(1);
    issue(`CMD_PAGE_PROG, 11'd1984);
    chk("masked error", {started, status[`FSR_LOCKERR_BIT], irq}, 3'b010);
    strobe(0);
    $display("lock test done");
  endtask
  task t_clear_supply;
    integer k;
    // the pin is synchronised, so hold it long enough to pass the chain
    calib_wr <= 1'b1;
    nv_clear <= 1'b1;
    repeat (8) @(posedge clk_i);
    nv_clear <= 1'b0;
    calib_wr <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("cleared", locks, 0);
    chk("protect cleared", status[`FSR_PROT_BIT], 0);
    chk("calib kept", calib, 32'h5a);
    for (k = 0; k < 2; k = k + 1) begin
      por_ok <= k[0];
      bod_ok <= ~k[0];
      issue(`CMD_SET_LOCK, 11'd64);
      chk("inhibited", {started, locks[1], status[`FSR_PROGE_BIT]}, 3'b001);
      por_ok <= 1'b1;
      bod_ok <= 1'b1;
      strobe(0);
    end
    issue(`CMD_CLR_GPNV, 11'd0);
    chk("bod off", bod_en, 0);
    issue(`CMD_SET_GPNV, 11'd0);
    chk("bod on", bod_en, 1);
    issue(4'hf, 11'd0);
    chk("unknown refused", {started, status[`FSR_PROGE_BIT]}, 2'b01);
    strobe(0);
    $display("clear and supply test done");
  endtask
  task t_straps;
    integer n;
    strap <= 4'b1110;
    repeat (10) @(posedge clk_i);
    chk("fast mode", fast_en, 1);
    strap <= 4'b1111;
    for (n = 0; n < 200 && restore !== 1'b1; n = n + 1)
      @(posedge clk_i);
    chk("restore time", (n >= 50 && n < 70), 1);
    @(posedge clk_i);
    chk("power cycle", {pcycle, fast_en}, 2'b10);
    $display("strap test done");
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    t_lock;
    t_clear_supply;
    t_straps;
    test_done;
  end
  // watchdog: whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count = err_count + 1;
    test_done;
  end
endmodule
